// ==== common/mts_pkg.sv ====
// Constants and carrier types for the transmit start and line clock block
package mts_pkg;
  localparam int unsigned START_BIT_POS = 13;
  localparam int unsigned SPEED_BIT_POS = 22;
  localparam int unsigned CLOCK_NS = 25;
  // Settle cycles in the DMA side before the first fetch
  localparam logic [2:0] DMA_LEAD_CYCLES = 3'h4;
  // Register side delay before the request toggles
  localparam logic [1:0] CSR_LEAD_CYCLES = 2'h2;
  localparam logic [3:0] DESC_WORDS = 4'h3;
  localparam logic [3:0] DATA_WORDS = 4'h2;
  localparam logic [4:0] DIV_FAST = 5'h02;
  localparam logic [4:0] DIV_SLOW = 5'h14;

  typedef enum logic [2:0] {
    MTS_IDLE = 3'b000,
    MTS_LEAD = 3'b001,
    MTS_DESC = 3'b010,
    MTS_DATA = 3'b011,
    MTS_LINE = 3'b100
  } mts_phase_t;

  // DMA request group
  typedef struct packed {
    logic req;
    logic is_data;
    logic fifo_wr;
  } mts_dma_t;
endpackage : mts_pkg

// ==== hdl/mts_line_clock.sv ====
// Line clock divider for RMII reference
module mts_line_clock
  import mts_pkg::*;
(
  // Reference clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Speed select, one means 100 Mbps
  input wire logic i_speed_100,
  // Derived line clock level
  output logic o_line_clock
);
  typedef struct packed {
    logic [4:0] cnt;
    logic clk;
    // Watch of the output level, used only by the period check
    logic last;
    logic [4:0] gap;
    logic slow;
  } mts_div_t;
  mts_div_t st_q, st_d;
  logic [4:0] half;

  // Half period count from the selected ratio
  always_comb begin
    half = i_speed_100 ? (DIV_FAST >> 1) : (DIV_SLOW >> 1);
    st_d = st_q;
    if (st_q.cnt >= half - 5'h01) begin
      st_d.cnt = 5'h00;
      st_d.clk = ~st_q.clk;
    end else begin
      st_d.cnt = st_q.cnt + 5'h01;
    end
    // Cycles since the level last moved, and whether slow mode held
    st_d.last = st_q.clk;
    if (st_q.clk != st_q.last) begin
      st_d.gap = 5'h01;
      st_d.slow = !i_speed_100;
    end else begin
      st_d.gap = (st_q.gap == 5'h1f) ? st_q.gap : st_q.gap + 5'h01;
      st_d.slow = st_q.slow && !i_speed_100;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_line_clock = st_q.clk;

  property p_div_slow;
    @(posedge i_clock) disable iff (!i_rst_n)
      st_q.slow && (st_q.gap <= (DIV_SLOW >> 1))
        |-> ((st_q.clk != st_q.last) == (st_q.gap == (DIV_SLOW >> 1)));
  endproperty
  a_div_slow: assert property (p_div_slow) else $error("slow div wrong");
  property p_div_fast;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_speed_100 && $past(i_speed_100) && $past(i_speed_100, 2)
        && $changed(st_q.clk) |=> $changed(st_q.clk);
  endproperty
  a_div_fast: assert property (p_div_fast) else $error("fast div wrong");
  c_toggle: cover property (@(posedge i_clock) $rose(o_line_clock));
endmodule : mts_line_clock

// ==== hdl/mts_tx_start.sv ====
// Transmit start sequencer with a single clock and RMII clock divider
module mts_tx_start
  import mts_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Operating mode bits from the register file
  input wire logic i_tx_start_bit,
  input wire logic i_speed_100,
  // DMA handshake
  input wire logic i_dma_acknowledge,
  output mts_pkg::mts_dma_t o_dma,
  // FIFO level reached and line done
  input wire logic i_fifo_ready,
  input wire logic i_line_done,
  // Status
  output logic o_tx_stopped,
  output logic o_line_start,
  output mts_pkg::mts_phase_t o_phase,
  // RMII derived line clock
  output logic o_line_clock
);
  typedef struct packed {
    logic [1:0] ack_sync;
    logic start_seen;
    logic stopped;
    logic [1:0] csr_cnt;
    logic req_tog;
    logic [1:0] req_sync;
    logic req_last;
    logic ack_tog;
    mts_phase_t phase;
    logic [2:0] lead;
    logic [3:0] words;
    logic line_start;
  } mts_state_t;
  mts_state_t st_q, st_d;
  logic [1:0] ack_pin_q;
  logic ack;

  // Acknowledge pin passes two flops
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ack_pin_q <= 2'h0;
    end else begin
      ack_pin_q <= {ack_pin_q[0], i_dma_acknowledge};
    end
  end
  assign ack = ack_pin_q[1];

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    st_d.line_start = 1'b0;
    // Start bit sampled, stopped falls next cycle
    st_d.start_seen = i_tx_start_bit;
    if (i_tx_start_bit && st_q.stopped) begin
      st_d.stopped = 1'b0;
      st_d.csr_cnt = CSR_LEAD_CYCLES;
    end else if (!i_tx_start_bit && st_q.phase == MTS_IDLE) begin
      st_d.stopped = 1'b1;
    end
    // Register side counts down then toggles request
    if (st_q.csr_cnt != 2'h0) begin
      st_d.csr_cnt = st_q.csr_cnt - 2'h1;
      if (st_q.csr_cnt == 2'h1) begin
        st_d.req_tog = ~st_q.req_tog;
      end
    end
    // Two stage sync of the request toggle
    st_d.req_sync = {st_q.req_sync[0], st_q.req_tog};
    st_d.req_last = st_q.req_sync[1];
    unique case (st_q.phase)
      MTS_IDLE: begin
        if (st_q.req_sync[1] != st_q.req_last) begin
          st_d.ack_tog = ~st_q.ack_tog;
          st_d.phase = MTS_LEAD;
          st_d.lead = DMA_LEAD_CYCLES - 3'h1;
        end
      end
      MTS_LEAD: begin
        if (st_q.lead == 3'h0) begin
          st_d.phase = MTS_DESC;
          st_d.words = DESC_WORDS;
        end else begin
          st_d.lead = st_q.lead - 3'h1;
        end
      end
      MTS_DESC: begin
        if (ack) begin
          st_d.words = st_q.words - 4'h1;
          if (st_q.words == 4'h1) begin
            st_d.phase = MTS_DATA;
            st_d.words = DATA_WORDS;
          end
        end
      end
      MTS_DATA: begin
        if (ack && st_q.words != 4'h0) begin
          st_d.words = st_q.words - 4'h1;
        end
        if ((st_q.words == 4'h0) && i_fifo_ready) begin
          st_d.phase = MTS_LINE;
          st_d.line_start = 1'b1;
        end
      end
      MTS_LINE: begin
        if (i_line_done) begin
          st_d.phase = MTS_IDLE;
        end
      end
      default: st_d.phase = MTS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.stopped <= 1'b1;
      st_q.phase <= MTS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Request held until each acknowledged word
  assign o_dma.req = (st_q.phase == MTS_DESC) ||
                     (st_q.phase == MTS_DATA && st_q.words != 4'h0);
  assign o_dma.is_data = (st_q.phase == MTS_DATA);
  assign o_dma.fifo_wr = (st_q.phase == MTS_DATA) && ack &&
                         (st_q.words != 4'h0);
  assign o_tx_stopped = st_q.stopped;
  assign o_line_start = st_q.line_start;
  assign o_phase = st_q.phase;

  // RMII line clock from reference
  mts_line_clock u_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_speed_100(i_speed_100),
    .o_line_clock(o_line_clock)
  );

  property p_stop_fall;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_tx_start_bit && st_q.stopped |=> !o_tx_stopped;
  endproperty
  a_stop_fall: assert property (p_stop_fall) else $error("no stop fall");
  property p_fetch_time;
    @(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_tx_stopped) |-> ##9 (st_q.phase == MTS_DESC);
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("fetch late");
  property p_sync_delay;
    @(posedge i_clock) disable iff (!i_rst_n)
      $changed(st_q.req_tog) |-> ##2 (st_q.req_sync[1] == st_q.req_tog);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay");
  property p_order;
    @(posedge i_clock) disable iff (!i_rst_n)
      $changed(st_q.phase) && st_q.phase == MTS_DATA
        |-> $past(st_q.phase) == MTS_DESC;
  endproperty
  a_order: assert property (p_order) else $error("phase order");
  property p_line_order;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_line_start |-> $past(st_q.phase) == MTS_DATA;
  endproperty
  a_line_order: assert property (p_line_order) else $error("line early");
  property p_req_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_dma.req && !ack && st_q.phase == MTS_DESC |=> o_dma.req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped");
  property p_ack_back;
    @(posedge i_clock) disable iff (!i_rst_n)
      st_q.phase == MTS_IDLE && (st_q.req_sync[1] != st_q.req_last)
        |=> $changed(st_q.ack_tog);
  endproperty
  a_ack_back: assert property (p_ack_back) else $error("no ack toggle");
  property p_start_seen;
    @(posedge i_clock) disable iff (!i_rst_n)
      !i_tx_start_bit && st_q.phase == MTS_IDLE |=> o_tx_stopped;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("no stop rise");
  c_desc: cover property (@(posedge i_clock) st_q.phase == MTS_DESC);
  c_data: cover property (@(posedge i_clock) o_dma.fifo_wr);
  c_line: cover property (@(posedge i_clock) o_line_start);
endmodule : mts_tx_start

// ==== tb/mts_ack_model.sv ====
// System memory side model answering DMA reads with acknowledges
module mts_ack_model
  import mts_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Request from the sequencer, acknowledge back
  input mts_pkg::mts_dma_t i_dma,
  output logic o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  initial o_ack = 1'b0;
  // One pulse per word after a random stall; gap covers the sync delay
  always begin
    @(posedge i_clock);
    if (i_rst_n === 1'b1 && i_dma.req === 1'b1) begin
      wait_n = $urandom_range(3, 0);
      repeat (wait_n) @(posedge i_clock);
      o_ack <= 1'b1;
      @(posedge i_clock);
      o_ack <= 1'b0;
      repeat (3) @(posedge i_clock);
    end
  end
endmodule : mts_ack_model

// ==== tb/tb_mac_tx_start_and_line_clocking.sv ====
// Self-checking bench for the transmit start sequencer
module tb_mac_tx_start_and_line_clocking
  import mts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic speed = 1'b1;
  logic fifo_rdy = 1'b0;
  logic done = 1'b0;
  logic ack, stopped, lstart, lclk;
  mts_dma_t dma;
  mts_phase_t phase;
  mts_phase_t last_ph = MTS_IDLE;
  mts_phase_t phq[$];
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int got_wr = 0;

  mts_tx_start dut (.i_clock(clk), .i_rst_n(rst_n), .i_tx_start_bit(start),
    .i_speed_100(speed), .i_dma_acknowledge(ack), .o_dma(dma),
    .i_fifo_ready(fifo_rdy), .i_line_done(done), .o_tx_stopped(stopped),
    .o_line_start(lstart), .o_phase(phase), .o_line_clock(lclk));
  mts_ack_model sys (.i_clock(clk), .i_rst_n(rst_n), .i_dma(dma),
    .o_ack(ack));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Cycle limit, data word count and phase history
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma.fifo_wr === 1'b1) got_wr++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
    #1;
    if (phase !== last_ph) begin
      phq.push_back(phase);
      last_ph = phase;
    end
  end

  // Verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Wait edges, then let updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Rising edges of the derived line clock over 200 cycles
  task automatic line_rate(input logic spd, input int div);
    int n;
    logic prev;
    n = 0;
    @(posedge clk);
    speed <= spd;
    tick(30);
    prev = lclk;
    repeat (200) begin
      tick(1);
      if (lclk === 1'b1 && prev === 1'b0) n++;
      prev = lclk;
    end
    chk("line_clock_rises", 200 / div, n);
  endtask : line_rate

  // Full start, fetch, fill and line sequence
  task automatic run_tx(input logic spd);
    int k;
    mts_phase_t exp_q[$];
    exp_q = '{MTS_LEAD, MTS_DESC, MTS_DATA, MTS_LINE, MTS_IDLE};
    phq.delete();
    got_wr = 0;
    @(posedge clk);
    start <= 1'b1;
    speed <= spd;
    #1;
    chk("stopped_before", 1, stopped);
    tick(1);
    chk("stopped_after", 0, stopped);
    tick(8);
    chk("desc_early", 0, phase == MTS_DESC);
    tick(1);
    chk("desc_phase", MTS_DESC, phase);
    chk("desc_req", 1, dma.req);
    chk("desc_is_data", 0, dma.is_data);
    for (k = 0; k < 400 && got_wr < DATA_WORDS; k++) begin
      tick(1);
      chk("early_line", 0, lstart);
    end
    chk("data_words", DATA_WORDS, got_wr);
    chk("data_is_data", 1, dma.is_data);
    repeat ($urandom_range(6, 1)) begin
      tick(1);
      chk("line_wait", 0, lstart);
    end
    @(posedge clk);
    fifo_rdy <= 1'b1;
    for (k = 0; k < 10 && lstart !== 1'b1; k++) tick(1);
    chk("line_start", 1, lstart);
    @(posedge clk);
    fifo_rdy <= 1'b0;
    start <= 1'b0;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    tick(4);
    chk("stopped_end", 1, stopped);
    chk("phase_count", exp_q.size(), phq.size());
    foreach (exp_q[i]) chk("phase_order", exp_q[i], phq[i]);
  endtask : run_tx

  // Reset, then the scenarios in order
  initial begin
    void'($urandom(32'h9e79));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    line_rate(1'b1, DIV_FAST);
    line_rate(1'b0, DIV_SLOW);
    run_tx(1'b1);
    run_tx(1'b0);
    @(posedge clk);
    start <= 1'b1;
    tick(12);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk("rst_stopped", 1, stopped);
    chk("rst_req", 0, dma.req);
    @(posedge clk);
    rst_n <= 1'b1;
    start <= 1'b0;
    tick(2);
    run_tx(1'b1);
    stop_test();
  end
endmodule : tb_mac_tx_start_and_line_clocking
